// ==== logic/eqreg_top.sv ====
// Output drive, output gating and signal-absent filter registers of a cable equalizer.
// Assumes an AXI4-Lite master on aclk and analog-side inputs that are asynchronous to aclk.
//
// Function
// - A 4-bit amplitude code in bits 14:11 of output_drive_config, reset B, is applied only while override is set.
// - Override bit 10 selects the programmed code when 1 and code B when 0.
// - Bit 9 picks a 100 ps (0) or 200 ps (1) de-emphasis delay, effective only while de-emphasis is on.
// - Bits 8:6 hold a de-emphasis strength, reset 0, effective only while de-emphasis is on.
// - Bit 1 of output_drive_config turns de-emphasis off at 0 and on at 1, reset 0.
// - Bit 2 of output_gate_config powers down the output buffer, reset 0.
// - With bit 1 of output_gate_config set, the output mutes while the signal-absent flag is set.
// - Mute bit 0 holds the two output halves at opposite static levels.
// - Bits 15:8 of link_status report the cable reach estimate in 2.5 m steps.
// - Bits 3:1 of link_status report the detected rate class, reset 001.
// - Bit 0 of link_status reads 1 while a qualified signal is present, reset 0.
// - Assertion of the signal-absent flag waits bits 15:8 of absence_filter_delays in 25.9 us steps.
// - Release of the signal-absent flag waits bits 7:0 in 6.6 ms steps, zero meaning no wait.
// - Bit 0 of absence_filter_control bypasses the filter so raw detection is used directly.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps

module eqreg_top #(
  parameter int ADDR_W           = 8,
  parameter int RELEASE_STEP_CYC = eqreg_pkg::RELEASE_STEP_CYC
) (
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic [ADDR_W-1:0]                     awaddr,
  input  wire logic [2:0]                            awprot,
  input  wire logic                                  awvalid,
  output logic                                       awready,
  input  wire logic [31:0]                           wdata,
  input  wire logic [3:0]                            wstrb,
  input  wire logic                                  wvalid,
  output logic                                       wready,
  output logic [1:0]                                 bresp,
  output logic                                       bvalid,
  input  wire logic                                  bready,
  input  wire logic [ADDR_W-1:0]                     araddr,
  input  wire logic [2:0]                            arprot,
  input  wire logic                                  arvalid,
  output logic                                       arready,
  output logic [31:0]                                rdata,
  output logic [1:0]                                 rresp,
  output logic                                       rvalid,
  input  wire logic                                  rready,
  input  wire logic                                  absent_raw_in,
  input  wire logic [eqreg_pkg::REACH_W-1:0]         reach_in,
  input  wire logic [eqreg_pkg::RATE_W-1:0]          rate_in,
  output eqreg_pkg::eqreg_drive_s                    drive_o,
  output logic                                       signal_absent_flag,
  output logic                                       irq
);
  import eqreg_pkg::*;

  localparam int SYNC_W = 1 + REACH_W + RATE_W;

  logic [15:0]             drive_reg;
  logic [15:0]             gate_reg;
  logic [15:0]             flt_dly_reg;
  logic [15:0]             flt_ctrl_reg;
  logic [IRQ_W-1:0]        irq_status_reg;
  logic [IRQ_W-1:0]        irq_status_next;
  logic [IRQ_W-1:0]        irq_mask_reg;
  logic [SYNC_W-1:0]       sync1_reg;
  logic [SYNC_W-1:0]       sync2_reg;
  logic                    raw_absent;
  logic [REACH_W-1:0]      reach_reg;
  logic [RATE_W-1:0]       rate_reg;
  logic                    present_reg;
  logic [PRE_W-1:0]        pre_cnt_reg;
  logic [HOLD_W-1:0]       step_cnt_reg;
  logic [HOLD_W-1:0]       hold_sel;
  logic [PRE_W-1:0]        step_len;
  logic                    bypass;
  logic                    aw_held_reg;
  logic [IDX_W-1:0]        aw_idx_reg;
  logic                    w_held_reg;
  logic [15:0]             wdata_reg;
  logic [1:0]              wstrb_reg;
  logic                    wr_fire;
  logic                    rd_fire;
  logic                    rd_clr;
  logic [IDX_W-1:0]        ar_idx;
  logic [15:0]             rd_word;
  logic                    rd_err;
  logic                    wr_err;
  logic [IRQ_W-1:0]        events;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] data,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  // Analog-side inputs pass two flops; the multi-bit status fields are slow-moving
  // indications, so a one-sample skew between their bits is tolerated.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Reset to the idle levels so no false rate change or presence follows reset.
      sync1_reg <= {1'b1, {REACH_W{1'b0}}, RATE_RST};
      sync2_reg <= {1'b1, {REACH_W{1'b0}}, RATE_RST};
    end else begin
      sync1_reg <= {absent_raw_in, reach_in, rate_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign raw_absent = sync2_reg[SYNC_W-1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reach_reg <= '0;
      rate_reg  <= RATE_RST;
    end else begin
      reach_reg <= sync2_reg[RATE_W +: REACH_W];
      rate_reg  <= sync2_reg[RATE_W-1:0];
    end
  end

  // Write channel: address and data are taken in either order, then one response.
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready     <= 1'b0;
      aw_held_reg <= 1'b0;
      aw_idx_reg  <= '0;
    end else begin
      awready <= awvalid && !awready && !aw_held_reg && !bvalid;
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= awaddr[IDX_W+1:2];
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready     <= 1'b0;
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else begin
      wready <= wvalid && !wready && !w_held_reg && !bvalid;
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= wdata[15:0];
        wstrb_reg  <= wstrb[1:0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_idx_reg)
      IDX_DRIVE, IDX_GATE, IDX_STATUS, IDX_FLT_DELAYS,
      IDX_FLT_CTRL, IDX_IRQ_STATUS, IDX_IRQ_MASK: wr_err = 1'b0;
      default:                                     wr_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Reserved bits are stored as written, except above bit 2 of the interrupt mask, so software that keeps them zero reads zero back.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_reg    <= DRIVE_RST;
      gate_reg     <= GATE_RST;
      flt_dly_reg  <= FLT_DLY_RST;
      flt_ctrl_reg <= FLT_CTRL_RST;
      irq_mask_reg <= '0;
    end else if (wr_fire) begin
      case (aw_idx_reg)
        IDX_DRIVE:      drive_reg    <= merge16(drive_reg, wdata_reg, wstrb_reg);
        IDX_GATE:       gate_reg     <= merge16(gate_reg, wdata_reg, wstrb_reg);
        IDX_FLT_DELAYS: flt_dly_reg  <= merge16(flt_dly_reg, wdata_reg, wstrb_reg);
        IDX_FLT_CTRL:   flt_ctrl_reg <= merge16(flt_ctrl_reg, wdata_reg, wstrb_reg);
        IDX_IRQ_MASK: begin
          if (wstrb_reg[0]) begin
            irq_mask_reg <= wdata_reg[IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel.
  assign ar_idx  = araddr[IDX_W+1:2];
  assign rd_fire = arvalid && arready;
  assign rd_clr  = rd_fire && (ar_idx == IDX_IRQ_STATUS);

  always_comb begin
    rd_word = '0;
    rd_err  = 1'b0;
    case (ar_idx)
      IDX_DRIVE:      rd_word = drive_reg;
      IDX_GATE:       rd_word = gate_reg;
      IDX_STATUS: begin
        rd_word[ST_REACH_LSB +: REACH_W] = reach_reg;
        rd_word[ST_RATE_LSB +: RATE_W]   = rate_reg;
        rd_word[ST_PRESENT_BIT]          = present_reg;
      end
      IDX_FLT_DELAYS: rd_word = flt_dly_reg;
      IDX_FLT_CTRL:   rd_word = flt_ctrl_reg;
      IDX_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status_reg;
      IDX_IRQ_MASK:   rd_word[IRQ_W-1:0] = irq_mask_reg;
      default:        rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata  <= {16'h0000, rd_word};
        rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Signal-absent filter: counts the time the raw condition differs from the flag.
  assign bypass   = flt_ctrl_reg[FCTL_BYPASS_BIT];
  assign hold_sel = signal_absent_flag ? flt_dly_reg[FLT_RELEASE_LSB +: HOLD_W]
                                       : flt_dly_reg[FLT_ASSERT_LSB +: HOLD_W];
  assign step_len = signal_absent_flag ? PRE_W'(RELEASE_STEP_CYC) : PRE_W'(ASSERT_STEP_CYC);

  // The flag starts set so the input is treated as absent until qualified.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      signal_absent_flag <= 1'b1;
      pre_cnt_reg        <= '0;
      step_cnt_reg       <= '0;
    end else if (bypass) begin
      signal_absent_flag <= raw_absent;
      pre_cnt_reg        <= '0;
      step_cnt_reg       <= '0;
    end else if (raw_absent == signal_absent_flag) begin
      pre_cnt_reg  <= '0;
      step_cnt_reg <= '0;
    end else if (step_cnt_reg == hold_sel) begin
      signal_absent_flag <= raw_absent;
      pre_cnt_reg        <= '0;
      step_cnt_reg       <= '0;
    end else if (pre_cnt_reg == step_len - PRE_W'(1)) begin
      pre_cnt_reg  <= '0;
      step_cnt_reg <= step_cnt_reg + HOLD_W'(1);
    end else begin
      pre_cnt_reg <= pre_cnt_reg + PRE_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      present_reg <= 1'b0;
    end else begin
      present_reg <= !signal_absent_flag;
    end
  end

  // Output drive controls toward the analog buffer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_o <= '0;
    end else begin
      drive_o.amp_code <= drive_reg[DRV_OVR_BIT] ? drive_reg[DRV_SWING_LSB +: AMP_W]
                                                 : AMP_DEFAULT;
      drive_o.emph_on        <= drive_reg[DRV_EMPH_BIT];
      drive_o.emph_tap_delay <= drive_reg[DRV_EMPH_BIT] && drive_reg[DRV_DLY_BIT];
      drive_o.emph_strength  <= drive_reg[DRV_EMPH_BIT] ? drive_reg[DRV_LVL_LSB +: LVL_W]
                                                        : '0;
      drive_o.power_down     <= gate_reg[GATE_PD_BIT];
      drive_o.mute           <= gate_reg[GATE_MUTE_BIT] ||
                                (gate_reg[GATE_AUTO_BIT] && signal_absent_flag);
    end
  end

  // Interrupts: a set in the same cycle as a clearing read survives.
  assign events[IRQ_ABSENT_BIT]  = !signal_absent_flag && !bypass && (raw_absent != signal_absent_flag)
                                   && (step_cnt_reg == hold_sel) ? 1'b1 :
                                   (bypass && raw_absent && !signal_absent_flag);
  assign events[IRQ_PRESENT_BIT] = signal_absent_flag && !raw_absent &&
                                   (bypass || (step_cnt_reg == hold_sel));
  assign events[IRQ_RATE_BIT]    = rate_reg != sync2_reg[RATE_W-1:0];
  assign irq_status_next         = (rd_clr ? '0 : irq_status_reg) | events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
      irq            <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq            <= |(irq_status_next & irq_mask_reg);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_mismatch;
    !bypass && (raw_absent != signal_absent_flag);
  endsequence

  sequence s_hold_done;
    s_mismatch ##0 (step_cnt_reg == hold_sel);
  endsequence

  property p_amp_code;
    1 |=> drive_o.amp_code == ($past(drive_reg[DRV_OVR_BIT])
                               ? $past(drive_reg[DRV_SWING_LSB +: AMP_W]) : AMP_DEFAULT);
  endproperty
  a_amp_code: assert property (p_amp_code) else $error("amplitude code mismatch");

  property p_emph;
    !drive_reg[DRV_EMPH_BIT] |=> !drive_o.emph_on && !drive_o.emph_tap_delay
                                 && drive_o.emph_strength == '0;
  endproperty
  a_emph: assert property (p_emph) else $error("de-emphasis active while disabled");

  property p_emph_fields;
    drive_reg[DRV_EMPH_BIT] |=> drive_o.emph_tap_delay == $past(drive_reg[DRV_DLY_BIT])
                                && drive_o.emph_strength == $past(drive_reg[DRV_LVL_LSB +: LVL_W]);
  endproperty
  a_emph_fields: assert property (p_emph_fields) else $error("de-emphasis fields wrong");

  property p_power_down;
    gate_reg[GATE_PD_BIT] ##1 gate_reg[GATE_PD_BIT] |-> drive_o.power_down;
  endproperty
  a_power_down: assert property (p_power_down) else $error("output not powered down");

  property p_mute;
    1 |=> drive_o.mute == ($past(gate_reg[GATE_MUTE_BIT])
                           || ($past(gate_reg[GATE_AUTO_BIT]) && $past(signal_absent_flag)));
  endproperty
  a_mute: assert property (p_mute) else $error("mute state wrong");

  property p_present;
    1 |=> present_reg == !$past(signal_absent_flag);
  endproperty
  a_present: assert property (p_present) else $error("presence bit wrong");

  property p_bypass;
    bypass |=> signal_absent_flag == $past(raw_absent);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not followed");

  property p_hold_done;
    s_hold_done |=> signal_absent_flag == $past(raw_absent);
  endproperty
  a_hold_done: assert property (p_hold_done) else $error("flag not changed at hold end");

  property p_no_early;
    !$past(bypass) && $changed(signal_absent_flag) |-> $past(step_cnt_reg) == $past(hold_sel);
  endproperty
  a_no_early: assert property (p_no_early) else $error("flag changed before hold");

  property p_restart;
    !bypass && (raw_absent == signal_absent_flag) |=> step_cnt_reg == '0 && pre_cnt_reg == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("filter count not restarted");

  property p_rate;
    1 |=> rate_reg == $past(sync2_reg[RATE_W-1:0]);
  endproperty
  a_rate: assert property (p_rate) else $error("rate class not tracked");

  property p_bvalid_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

endmodule : eqreg_top

// ==== logic/eqreg_pkg.sv ====
// Package of the equalizer output and signal-detect register bank.
// Assumes one 40 MHz clock and a 32-bit AXI4-Lite register bus.
package eqreg_pkg;

  // Clock and filter step timing.
  localparam int CLK_PERIOD_NS    = 25;
  localparam int ASSERT_STEP_NS   = 25900;
  localparam int ASSERT_STEP_CYC  = ASSERT_STEP_NS / CLK_PERIOD_NS;
  localparam int RELEASE_STEP_NS  = 6600000;
  localparam int RELEASE_STEP_CYC = RELEASE_STEP_NS / CLK_PERIOD_NS;
  localparam int PRE_W            = 20;

  // Register indices; the byte address is four times the index.
  localparam int          IDX_W          = 6;
  localparam logic [5:0]  IDX_DRIVE      = 6'h04;
  localparam logic [5:0]  IDX_GATE       = 6'h05;
  localparam logic [5:0]  IDX_STATUS     = 6'h06;
  localparam logic [5:0]  IDX_FLT_DELAYS = 6'h07;
  localparam logic [5:0]  IDX_FLT_CTRL   = 6'h08;
  localparam logic [5:0]  IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0]  IDX_IRQ_MASK   = 6'h11;

  // Field positions and widths.
  localparam int AMP_W           = 4;
  localparam int LVL_W           = 3;
  localparam int HOLD_W          = 8;
  localparam int REACH_W         = 8;
  localparam int RATE_W          = 3;
  localparam int DRV_SWING_LSB   = 11;
  localparam int DRV_OVR_BIT     = 10;
  localparam int DRV_DLY_BIT     = 9;
  localparam int DRV_LVL_LSB     = 6;
  localparam int DRV_EMPH_BIT    = 1;
  localparam int GATE_PD_BIT     = 2;
  localparam int GATE_AUTO_BIT   = 1;
  localparam int GATE_MUTE_BIT   = 0;
  localparam int ST_REACH_LSB    = 8;
  localparam int ST_RATE_LSB     = 1;
  localparam int ST_PRESENT_BIT  = 0;
  localparam int FLT_ASSERT_LSB  = 8;
  localparam int FLT_RELEASE_LSB = 0;
  localparam int FCTL_BYPASS_BIT = 0;
  localparam int IRQ_W           = 3;
  localparam int IRQ_ABSENT_BIT  = 0;
  localparam int IRQ_PRESENT_BIT = 1;
  localparam int IRQ_RATE_BIT    = 2;

  // Reset values.
  localparam logic [15:0]       DRIVE_RST     = 16'h5800;
  localparam logic [15:0]       GATE_RST      = 16'h0000;
  localparam logic [15:0]       FLT_DLY_RST   = 16'h0201;
  localparam logic [15:0]       FLT_CTRL_RST  = 16'h0000;
  localparam logic [AMP_W-1:0]  AMP_DEFAULT   = 4'hB;
  localparam logic [RATE_W-1:0] RATE_RST      = 3'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [AMP_W-1:0] amp_code;
    logic             emph_on;
    logic             emph_tap_delay;
    logic [LVL_W-1:0] emph_strength;
    logic             power_down;
    logic             mute;
  } eqreg_drive_s;

endpackage : eqreg_pkg

// ==== tb/eqreg_tb.sv ====
// Self-checking bench of the equalizer output and signal-detect register bank.
// Assumes eqreg_pkg and eqreg_top are compiled first; the bench drives every port itself.
`timescale 1ns/1ps

module tb;
  import eqreg_pkg::*;

  typedef struct {
    logic [7:0]  addr;
    logic [15:0] rst;
    logic [15:0] wr;
    logic [15:0] rd;
    logic [1:0]  resp;
  } eqreg_row_s;

  logic               aclk = 1'b0;
  logic               aresetn;
  logic [7:0]         awaddr, araddr;
  logic [2:0]         awprot, arprot;
  logic               awvalid, wvalid, bready, arvalid, rready;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  logic               absent_raw_in;
  logic [7:0]         reach_in;
  logic [2:0]         rate_in;
  eqreg_drive_s       drive_o;
  logic               signal_absent_flag;
  logic               irq;
  int                 err_total = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;

  // Status reset shows rate class 001 with the inputs held at reach 0 and rate 001.
  eqreg_row_s rows [7] = '{
    '{8'h10, 16'h5800, 16'h2EC2, 16'h2EC2, RESP_OKAY},
    '{8'h14, 16'h0000, 16'h0005, 16'h0005, RESP_OKAY},
    '{8'h18, 16'h0002, 16'hFFFF, 16'h0002, RESP_OKAY},
    '{8'h1C, 16'h0201, 16'h0301, 16'h0301, RESP_OKAY},
    '{8'h20, 16'h0000, 16'h0000, 16'h0000, RESP_OKAY},
    '{8'h44, 16'h0000, 16'h0001, 16'h0001, RESP_OKAY},
    '{8'h30, 16'h0000, 16'h1234, 16'h0000, RESP_SLVERR}
  };
  logic [15:0] dw [3] = '{16'h2EC2, 16'h2EC0, 16'h2AC2};
  logic [10:0] dx [3] = '{11'b01011101111, 11'b01010000011, 11'b10111101111};

  eqreg_top #(.ADDR_W(8), .RELEASE_STEP_CYC(20)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .absent_raw_in(absent_raw_in), .reach_in(reach_in), .rate_in(rate_in),
    .drive_o(drive_o), .signal_absent_flag(signal_absent_flag), .irq(irq)
  );

  always #12.5 aclk = ~aclk;

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // The ceiling leaves ample room over the longest filter wait of about 3100 cycles.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      $display("Error at %0t: timeout", $time);
      conclude();
    end
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    aresetn = 1'b0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    absent_raw_in = 1'b1;
    reach_in = 8'h00;
    rate_in = 3'h1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      axr(rows[i].addr, d, r);
      chk({r, d}, {rows[i].resp, 16'h0000, rows[i].rst}, "reset read");
    end
    foreach (rows[i]) begin
      axw(rows[i].addr, rows[i].wr, r);
      chk({32'h0, r}, {32'h0, rows[i].resp}, "write resp");
      axr(rows[i].addr, d, r);
      chk({r, d}, {rows[i].resp, 16'h0000, rows[i].rd}, "read back");
    end
    foreach (dw[i]) begin
      axw(8'h10, dw[i], r);
      @(posedge aclk);
      chk({23'h0, drive_o}, {23'h0, dx[i]}, "drive out");
    end
    // Automatic mute with the flag still high from reset.
    axw(8'h14, 16'h0002, r);
    @(posedge aclk);
    chk({32'h0, drive_o.power_down, drive_o.mute}, 34'h1, "auto mute");
    reach_in <= 8'hEF;
    rate_in <= 3'h4;
    absent_raw_in <= 1'b0;
    n = 0;
    while (signal_absent_flag !== 1'b0) begin
      @(posedge aclk);
      n++;
    end
    chk({33'h0, n >= 20 && n <= 30}, 34'h1, "release time");
    @(posedge aclk);
    chk({33'h0, drive_o.mute}, 34'h0, "unmute");
    axr(8'h18, d, r);
    chk({r, d}, {RESP_OKAY, 32'h0000EF09}, "status");
    chk({33'h0, irq}, 34'h0, "masked irq");
    axr(8'h40, d, r);
    chk({r, d}, {RESP_OKAY, 32'h6}, "irq status");
    axr(8'h40, d, r);
    chk({r, d}, {RESP_OKAY, 32'h0}, "irq cleared");
    // A short return to presence must restart the 3 x 1036 cycle assertion count.
    absent_raw_in <= 1'b1;
    repeat (2000) @(posedge aclk);
    absent_raw_in <= 1'b0;
    repeat (3) @(posedge aclk);
    absent_raw_in <= 1'b1;
    n = 0;
    while (signal_absent_flag !== 1'b1) begin
      @(posedge aclk);
      n++;
    end
    chk({33'h0, n >= 3108 && n <= 3120}, 34'h1, "assert time");
    repeat (2) @(posedge aclk);
    chk({32'h0, irq, drive_o.mute}, 34'h3, "irq and mute");
    axr(8'h40, d, r);
    chk({r, d}, {RESP_OKAY, 32'h1}, "irq status");
    repeat (2) @(posedge aclk);
    chk({33'h0, irq}, 34'h0, "irq low");
    axw(8'h20, 16'h0001, r);
    absent_raw_in <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({33'h0, signal_absent_flag}, 34'h0, "bypass low");
    absent_raw_in <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({33'h0, signal_absent_flag}, 34'h1, "bypass high");
    // A reset in mid-run returns outputs and registers to their reset state.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({21'h0, irq, signal_absent_flag, drive_o}, {21'h0, 2'h1, 4'hB, 7'h00}, "reset out");
    // The status row is skipped here because the inputs no longer show reach 0 and rate 001.
    foreach (rows[i]) begin
      if (i != 2) begin
        axr(rows[i].addr, d, r);
        chk({r, d}, {rows[i].resp, 16'h0000, rows[i].rst}, "reset again");
      end
    end
    conclude();
  end
endmodule : tb
